/* hdl/vcfs_pkg.sv */
// Constants for the video capture field sequencer.
// Assumes a 32-bit classic Wishbone register bus.
package vcfs_pkg;
	// Register byte offsets
	localparam logic [3:0] CTRL_OFS = 4'h0;
	localparam logic [3:0] STAT_OFS = 4'h4;
	localparam logic [3:0] MASK_OFS = 4'h8;
	localparam logic [3:0] INFO_OFS = 4'hC;
	// Control field positions
	localparam int F1SEL_BIT = 0;
	localparam int F2SEL_BIT = 1;
	localparam int FRAME_BIT = 2;
	localparam int CONT_BIT = 3;
	localparam int ENABLE_BIT = 4;
	// Status field positions
	localparam int F1C_BIT = 0;
	localparam int F2C_BIT = 1;
	localparam int FRAME_COMPLETE_FLAG_BIT = 2;
	// Reset values
	localparam logic [4:0] CTRL_RST = 5'h00;
	localparam logic [2:0] STAT_RST = 3'h0;
	localparam logic [2:0] MASK_RST = 3'h0;
	// Mode encodings {continuous, frame, field2_select, field1_select}
	localparam logic [3:0] M_NC_F1 = 4'h1;
	localparam logic [3:0] M_NC_F2 = 4'h2;
	localparam logic [3:0] M_NC_F12 = 4'h3;
	localparam logic [3:0] M_NC_FRM = 4'h4;
	localparam logic [3:0] M_NC_PRG = 4'h5;
	localparam logic [3:0] M_SINGLE = 4'h7;
	localparam logic [3:0] M_C_F1 = 4'h9;
	localparam logic [3:0] M_C_F2 = 4'hA;
	localparam logic [3:0] M_C_FRM = 4'hC;
	localparam logic [3:0] M_C_PRG = 4'hD;
endpackage : vcfs_pkg

/* hdl/vcfs_top.sv */
// Field and frame capture sequencer with Wishbone registers.
// Assumes field_start and field_done are one-cycle pulses on clk.
//
// Decided for this implementation: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
// What this block does
// RULE_01 - Continuous mode captures fields while enabled
// RULE_02 - Noncontinuous mode sets matching completion flag
// RULE_03 - After flag set, at most one more
// RULE_04 - Halted: store nothing, recheck flag each field
// RULE_05 - Mode 0001: field 1 only, wait clear
// RULE_06 - Mode 0010: field 2 only, wait clear
// RULE_07 - Mode 0011: both fields, separate flags
// RULE_08 - Mode 0100: frame flag, halt next frame
// RULE_09 - Mode 0101: progressive frame, halt next
// RULE_10 - Mode 0111: single frame, wait clear
// RULE_11 - Mode 1001: every field 1, flag anyway
// RULE_12 - Software clears field-1 flag during field 2
// RULE_13 - Mode 1010: every field 2, flag anyway
// RULE_14 - Mode 1100: continuous frames, flag after field 2
// RULE_15 - Mode 1101: continuous progressive, flag anyway
// RULE_16 - Reserved encodings capture nothing
// RULE_17 - Completion pulse whenever a flag sets
module vcfs_top (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Field timing from the front end
	input wire logic field_start,
	input wire logic field_is_f2,
	input wire logic field_done,
	// Capture control to the data path
	output logic capture_active,
	output logic capture_complete_irq,
	output logic irq
);
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_CAPT = 2'b01,
		ST_SKIP = 2'b11
	} vcfs_state_e;

	vcfs_state_e state_q, state_d;
	logic [4:0] ctrl_q, ctrl_d;
	logic [2:0] stat_q, stat_d;
	logic [2:0] mask_q, mask_d;
	logic [2:0] pend_q, pend_d;
	logic cur_f2_q, cur_f2_d;
	logic pulse_q, pulse_d;
	logic [31:0] rdat_d;
	logic ack_d;
	logic [3:0] mode;
	logic enable;
	logic cont;
	logic want_f1, want_f2, frame_mode, legal;
	logic wanted, blocked;
	logic [2:0] set_vec, clr_vec;
	logic [2:0] flag_sel;
	logic wr;

	assign mode = ctrl_q[vcfs_pkg::CONT_BIT:vcfs_pkg::F1SEL_BIT];
	assign enable = ctrl_q[vcfs_pkg::ENABLE_BIT];
	assign cont = ctrl_q[vcfs_pkg::CONT_BIT];
	assign frame_mode = ctrl_q[vcfs_pkg::FRAME_BIT];
	assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;

	// Mode decode
	always_comb begin
		want_f1 = 1'b0;
		want_f2 = 1'b0;
		legal = 1'b1;
		unique case (mode)
			vcfs_pkg::M_NC_F1, vcfs_pkg::M_C_F1,
			vcfs_pkg::M_NC_PRG, vcfs_pkg::M_C_PRG: begin
				want_f1 = 1'b1; // RULE_05 RULE_09 RULE_11 RULE_15
			end
			vcfs_pkg::M_NC_F2, vcfs_pkg::M_C_F2: begin
				want_f2 = 1'b1; // RULE_06 RULE_13
			end
			vcfs_pkg::M_NC_F12, vcfs_pkg::M_NC_FRM,
			vcfs_pkg::M_SINGLE, vcfs_pkg::M_C_FRM: begin
				want_f1 = 1'b1; // RULE_07 RULE_08 RULE_10 RULE_14
				want_f2 = 1'b1;
			end
			default: begin
				legal = 1'b0; // RULE_16
			end
		endcase
	end

	// Flag that completes on this field, and halt check at field start
	always_comb begin
		flag_sel = 3'h0;
		// Field kind is only valid with field_start, so use the held copy
		if (frame_mode) begin
			// Progressive frame ends after field 1, else after field 2
			if ((mode[1:0] == 2'b01) ? ~cur_f2_q : cur_f2_q) begin
				flag_sel[vcfs_pkg::FRAME_COMPLETE_FLAG_BIT] = 1'b1; // RULE_08 RULE_10
			end
		end else if (cur_f2_q) begin
			flag_sel[vcfs_pkg::F2C_BIT] = 1'b1;
		end else begin
			flag_sel[vcfs_pkg::F1C_BIT] = 1'b1;
		end
		wanted = legal & enable & (field_is_f2 ? want_f2 : want_f1);
		blocked = 1'b0;
		if (!cont) begin
			if (mode == vcfs_pkg::M_SINGLE) begin
				blocked = stat_q[vcfs_pkg::FRAME_COMPLETE_FLAG_BIT]; // RULE_10
			end else if (frame_mode) begin
				// One more frame may run after the flag sets
				blocked = pend_q[vcfs_pkg::FRAME_COMPLETE_FLAG_BIT]; // RULE_03 RULE_08 RULE_09
			end else if (field_is_f2) begin
				blocked = stat_q[vcfs_pkg::F2C_BIT]; // RULE_06 RULE_07
			end else begin
				blocked = stat_q[vcfs_pkg::F1C_BIT]; // RULE_05 RULE_07
			end
		end
	end

	// Field sequencer
	always_comb begin
		state_d = state_q;
		cur_f2_d = cur_f2_q;
		set_vec = 3'h0;
		if (field_start) begin
			cur_f2_d = field_is_f2;
			if (!wanted) begin
				state_d = ST_IDLE;
			end else if (blocked) begin
				state_d = ST_SKIP; // RULE_04
			end else begin
				state_d = ST_CAPT; // RULE_01
			end
		end else if (field_done && state_q == ST_CAPT) begin
			state_d = ST_IDLE;
			// Completion sets a flag in every legal mode, but not after field 1 in modes 0100, 0111 and 1100
			set_vec = flag_sel; // RULE_02 RULE_11 RULE_13 RULE_14 RULE_15
		end else if (field_done) begin
			state_d = ST_IDLE;
		end
	end

	// Frame halt tracking: armed when frame flag sets while already set
	always_comb begin
		pend_d = pend_q;
		if (set_vec[vcfs_pkg::FRAME_COMPLETE_FLAG_BIT] && stat_q[vcfs_pkg::FRAME_COMPLETE_FLAG_BIT]) begin
			pend_d[vcfs_pkg::FRAME_COMPLETE_FLAG_BIT] = 1'b1; // RULE_03
		end
		if (!stat_q[vcfs_pkg::FRAME_COMPLETE_FLAG_BIT] || cont) begin
			pend_d[vcfs_pkg::FRAME_COMPLETE_FLAG_BIT] = 1'b0;
		end
		pend_d[vcfs_pkg::F2C_BIT:vcfs_pkg::F1C_BIT] = 2'b00;
	end

	// Register file
	always_comb begin
		ctrl_d = ctrl_q;
		mask_d = mask_q;
		clr_vec = 3'h0;
		if (wr && wb_sel_i[0]) begin
			unique case (wb_adr_i)
				vcfs_pkg::CTRL_OFS: ctrl_d = wb_dat_i[4:0];
				vcfs_pkg::STAT_OFS: clr_vec = wb_dat_i[2:0];
				vcfs_pkg::MASK_OFS: mask_d = wb_dat_i[2:0];
				default: ;
			endcase
		end
		// Set wins over a clear in the same cycle
		stat_d = (stat_q & ~clr_vec) | set_vec;
		pulse_d = |set_vec; // RULE_17
		ack_d = wb_cyc_i & wb_stb_i & ~wb_ack_o;
		rdat_d = 32'h0000_0000;
		unique case (wb_adr_i)
			vcfs_pkg::CTRL_OFS: rdat_d = {27'h0, ctrl_q};
			vcfs_pkg::STAT_OFS: rdat_d = {29'h0, stat_q};
			vcfs_pkg::MASK_OFS: rdat_d = {29'h0, mask_q};
			vcfs_pkg::INFO_OFS: rdat_d = {28'h0, cur_f2_q,
				state_q == ST_SKIP, state_q == ST_CAPT, legal};
			default: rdat_d = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_q <= ST_IDLE;
			ctrl_q <= vcfs_pkg::CTRL_RST;
			stat_q <= vcfs_pkg::STAT_RST;
			mask_q <= vcfs_pkg::MASK_RST;
			pend_q <= 3'h0;
			cur_f2_q <= 1'b0;
			pulse_q <= 1'b0;
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			state_q <= state_d;
			ctrl_q <= ctrl_d;
			stat_q <= stat_d;
			mask_q <= mask_d;
			pend_q <= pend_d;
			cur_f2_q <= cur_f2_d;
			pulse_q <= pulse_d;
			wb_ack_o <= ack_d;
			wb_dat_o <= rdat_d;
		end
	end

	assign capture_active = (state_q == ST_CAPT); // RULE_04
	assign capture_complete_irq = pulse_q; // RULE_17
	assign irq = |(stat_q & mask_q);
endmodule : vcfs_top

/* dv/vcfs_monitor.sv */
// Port checker for the field sequencer.
// Assumes it is bound into vcfs_top, one clock domain.
`timescale 1ns/1ps
module vcfs_monitor (
	// Clock, reset and bus
	input wire logic clk, sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o,
	// Field timing and capture outputs
	input wire logic field_start, field_done, capture_active,
	input wire logic capture_complete_irq, irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	a_ack_timely: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=>
		wb_ack_o) else $error("ack late");
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held");
	a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	a_cmp_pulse: assert property (capture_complete_irq |=>
		!capture_complete_irq) else $error("complete too long");
	a_cmp_cause: assert property (capture_complete_irq |->
		$past(field_done && capture_active)) else $error("complete unasked");
	a_start_field: assert property ($rose(capture_active) |->
		$past(field_start)) else $error("capture mid field");
	a_active_ends: assert property (capture_active && field_done |=>
		!capture_active) else $error("capture past end");
	a_irq_sticky: assert property (irq && !(wb_cyc_i && wb_stb_i &&
		wb_we_i) |=> irq) else $error("irq lost");
	cover property (capture_complete_irq);
	cover property (irq);
	cover property ($rose(capture_active));
endmodule : vcfs_monitor
bind vcfs_top vcfs_monitor u_mon (.*);

/* dv/vcfs_field_src.sv */
// Field source model: one field per go request.
// Assumes go is a one-cycle request while idle.
`timescale 1ns/1ps
module vcfs_field_src (
	// Clock and request
	input wire logic clk, go, f2,
	// Field timing
	output logic field_start = 0, field_is_f2 = 0, field_done = 0
);
	int n = 0;
	always @(posedge clk) begin
		field_start <= go && n == 0;
		field_done <= n == 6;
		if (go && n == 0) begin
			n <= 1;
			field_is_f2 <= f2;
		end else if (n != 0) begin
			n <= n == 8 ? 0 : n + 1;
			// Field kind not held past field start
			field_is_f2 <= n == 3 ? !field_is_f2 : field_is_f2;
		end
	end
endmodule : vcfs_field_src

/* dv/vcfs_tb_top.sv */
// Testbench for the field sequencer: table of field steps.
// Assumes vcfs_top, vcfs_pkg and the field source model.
`timescale 1ns/1ps
module vcfs_tb_top;
	logic clk = 0, sys_rst = 1, cyc = 0, stb = 0, we = 0, go = 0, f2 = 0;
	logic [3:0] adr = 0;
	logic [31:0] dat = 0, q, rd;
	logic fs, fi, fd, ca, cc, irq, ack;
	int miscompares = 0, total_checks = 0;
	// Row: {clear, disable, -, field2}, mode, captured, status
	logic [15:0] rows [33] = '{16'h8111, 16'h1101, 16'h0101, 16'h8111,
		16'h8200, 16'h1212, 16'h1202, 16'h8311, 16'h1313, 16'h0303,
		16'h8710, 16'h1714, 16'h0704, 16'h8911, 16'h0911, 16'h9A12,
		16'h1A12, 16'h8C10, 16'h1C14, 16'h0C14, 16'h8D14, 16'h0D14,
		16'h8410, 16'h1414, 16'h0414, 16'h1414, 16'h0404, 16'h8514,
		16'h0514, 16'h0504, 16'h8000, 16'h9F00, 16'hC900};
	initial forever #5 clk = ~clk;
	vcfs_field_src src (.clk(clk), .go(go), .f2(f2), .field_start(fs),
		.field_is_f2(fi), .field_done(fd));
	vcfs_top dut (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
		.wb_dat_i(dat), .wb_dat_o(rd), .wb_ack_o(ack), .field_start(fs),
		.field_is_f2(fi), .field_done(fd), .capture_active(ca),
		.capture_complete_irq(cc), .irq(irq));
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		dat <= d;
		do @(posedge clk);
		while (ack !== 1'b1);
		q = rd;
		cyc <= 0;
		stb <= 0;
		@(posedge clk);
	endtask : wb
	task automatic fld(input logic b, output logic seen, output logic pls);
		go <= 1;
		f2 <= b;
		seen = 0;
		pls = 0;
		@(posedge clk);
		go <= 0;
		repeat (11) begin
			@(posedge clk);
			seen |= ca;
			pls |= cc;
		end
	endtask : fld
	task automatic chk(input string n, input logic [31:0] e, s);
		total_checks++;
		if (s !== e) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task end_of_test;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : end_of_test
	initial begin
		#100000;
		miscompares++;
		end_of_test();
	end
	initial begin
		logic c, p;
		repeat (2) @(posedge clk);
		sys_rst <= 0;
		@(posedge clk);
		for (int i = 0; i < 14; i += 2) begin
			wb(0, 4'(i), 0);
			chk("reset read", 0, q);
		end
		$display("reset values done");
		wb(1, vcfs_pkg::MASK_OFS, 7);
		foreach (rows[i]) begin
			if (rows[i][15]) wb(1, vcfs_pkg::STAT_OFS, 7);
			wb(1, vcfs_pkg::CTRL_OFS, 32'({!rows[i][14], rows[i][11:8]}));
			fld(rows[i][12], c, p);
			wb(0, vcfs_pkg::STAT_OFS, 0);
			chk("captured", 32'(rows[i][4]), 32'(c));
			chk("status", 32'(rows[i][2:0]), q);
			chk("irq", 32'(|rows[i][2:0]), 32'(irq));
			chk("complete pulse", 32'(rows[i][4] & (!rows[i][10] |
				(rows[i][9:8] == 2'b01 ? !rows[i][12] : rows[i][12]))),
				32'(p));
			$display("row %0d done", i);
		end
		wb(1, vcfs_pkg::CTRL_OFS, 32'h19);
		fld(0, c, p);
		chk("continuous pulse", 1, 32'(p));
		wb(1, vcfs_pkg::MASK_OFS, 0);
		chk("masked irq", 0, 32'(irq));
		wb(1, vcfs_pkg::MASK_OFS, 1);
		chk("raised irq", 1, 32'(irq));
		wb(1, vcfs_pkg::STAT_OFS, 1);
		chk("cleared irq", 0, 32'(irq));
		$display("irq test done");
		sys_rst <= 1;
		@(posedge clk);
		sys_rst <= 0;
		@(posedge clk);
		wb(0, vcfs_pkg::CTRL_OFS, 0);
		chk("ctrl after reset", 0, q);
		$display("mid reset done");
		end_of_test();
	end
endmodule : vcfs_tb_top
